// >>> logic/plvs_pkg.sv
package plvs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int LVL_W  = 14;
  localparam int COEF_W = 8;
  localparam int VOLT_W = 10;
  localparam int SEC_W  = 10;
  localparam int FREQ_W = 6;

  // ****************************************************************
  // Settings defaults and ranges (hundredths for levels)
  // ****************************************************************
  localparam logic [LVL_W-1:0]  LVL_MAX_SET     = 14'h270f;
  localparam logic [LVL_W-1:0]  ZERO_DEF        = 14'h0000;
  localparam logic [LVL_W-1:0]  MIN_DEF         = 14'h0032;
  localparam logic [LVL_W-1:0]  START_DEF       = 14'h0064;
  localparam logic [LVL_W-1:0]  STOP_DEF        = 14'h00c8;
  localparam logic [LVL_W-1:0]  MAXL_DEF        = 14'h03e8;
  localparam logic [COEF_W-1:0] COEF_MAX        = 8'hc8;
  localparam logic [COEF_W-1:0] COEF_DEF        = 8'h32;
  localparam logic [SEC_W-1:0]  FLT_DLY_MAX     = 10'h3e7;
  localparam logic [SEC_W-1:0]  FLT_DLY_DEF     = 10'h001;
  localparam logic [SEC_W-1:0]  START_DLY_MIN   = 10'h004;
  localparam logic [SEC_W-1:0]  START_DLY_MAX   = 10'h063;
  localparam logic [SEC_W-1:0]  START_DLY_DEF   = 10'h004;
  localparam logic [SEC_W-1:0]  STOP_DLY_MAX    = 10'h063;
  localparam logic [SEC_W-1:0]  STOP_DLY_DEF    = 10'h001;
  localparam logic [SEC_W-1:0]  VOLT_DLY_MAX    = 10'h063;
  localparam logic [SEC_W-1:0]  VOLT_DLY_DEF    = 10'h005;
  localparam logic [VOLT_W-1:0] VMAX3_DEF       = 10'h1b8;
  localparam logic [VOLT_W-1:0] VMAX3_LO        = 10'h190;
  localparam logic [VOLT_W-1:0] VMAX3_HI        = 10'h1cc;
  localparam logic [VOLT_W-1:0] VMIN3_DEF       = 10'h168;
  localparam logic [VOLT_W-1:0] VMIN3_LO        = 10'h154;
  localparam logic [VOLT_W-1:0] VMIN3_HI        = 10'h190;
  localparam logic [VOLT_W-1:0] VMAX1_DEF       = 10'h0fd;
  localparam logic [VOLT_W-1:0] VMAX1_LO        = 10'h0e6;
  localparam logic [VOLT_W-1:0] VMAX1_HI        = 10'h104;
  localparam logic [VOLT_W-1:0] VMIN1_DEF       = 10'h0cf;
  localparam logic [VOLT_W-1:0] VMIN1_LO        = 10'h0c8;
  localparam logic [VOLT_W-1:0] VMIN1_HI        = 10'h0e6;
  localparam logic [FREQ_W-1:0] FREQ_LO         = 6'h32;
  localparam logic [FREQ_W-1:0] FREQ_HI         = 6'h3c;
  localparam logic [FREQ_W-1:0] FREQ_DEF        = 6'h32;

  // ****************************************************************
  // Tick timing
  // ****************************************************************
  localparam longint CLK_HZ   = 250000000;
  localparam longint TICK_S   = 1;
  localparam longint TICK_CYC = CLK_HZ * TICK_S;

  // ****************************************************************
  // Operating programs
  // ****************************************************************
  typedef enum logic [2:0] {
    PLVS_MODE_DARK_EMPTY  = 3'h0,
    PLVS_MODE_CLEAN_EMPTY = 3'h1,
    PLVS_MODE_DIGIT_EMPTY = 3'h2,
    PLVS_MODE_DIGIT_FILL  = 3'h3,
    PLVS_MODE_MULTI_TANK  = 3'h4,
    PLVS_MODE_CLEAN_FILL  = 3'h5
  } plvs_mode_type;

  typedef enum logic [1:0] {
    PLVS_P_OFF      = 2'h0,
    PLVS_P_START_WT = 2'h1,
    PLVS_P_RUN      = 2'h2,
    PLVS_P_STOP_WT  = 2'h3
  } plvs_pump_type;

  // Settings written by the operator panel
  typedef struct packed {
    logic [LVL_W-1:0]  zero;
    logic [LVL_W-1:0]  min_lvl;
    logic [LVL_W-1:0]  start_lvl;
    logic [LVL_W-1:0]  stop_lvl;
    logic [LVL_W-1:0]  max_lvl;
    logic [COEF_W-1:0] coef;
    logic              max_start_en;
    logic              float_alarm_pump_action;
    logic [SEC_W-1:0]  float_dly;
    logic [SEC_W-1:0]  start_dly;
    logic [SEC_W-1:0]  stop_dly;
    logic              volt_en;
    logic [VOLT_W-1:0] vmax;
    logic [VOLT_W-1:0] vmin;
    logic [SEC_W-1:0]  volt_dly;
    logic [FREQ_W-1:0] freq;
  } plvs_cfg_type;

  // Alarm flags toward display and relays
  typedef struct packed {
    logic min_alarm;
    logic max_alarm;
    logic float_alarm;
    logic volt_alarm;
  } plvs_alm_type;

endpackage

// >>> logic/plvs_sec_timer.sv
`timescale 1ns/10ps
module plvs_sec_timer
  import plvs_pkg::*;
#(
  parameter int W = SEC_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Control
  input  wire logic         i_run,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  // Status
  output logic              o_done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // ****************************************************************
  // Seconds counter, cleared whenever run drops
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    if (!i_run) begin
      cnt_nxt = '0;
    end else if (i_tick && cnt_r < i_limit) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_done = i_run && (cnt_r >= i_limit);
endmodule

// >>> logic/plvs_supervisor.sv
// How it works
// - Relative zero 00.00..99.99, reset 00.00, subtracted from the reading.
// - At or below minimum threshold: minimum alarm, pump stops.
// - Start threshold starts pump 1 only in digit and multi-tank modes.
// - Stop threshold stops pump 1 only in digit and multi-tank modes.
// - At or above maximum threshold: maximum alarm; pump starts if max-start set.
// - First-order filter, coefficient 0..200 default 50; larger is slower.
// - Float action set: emptying starts all pumps up to limit, filling stops.
// - Float action clear: float only raises its alarm.
// - Float-open pump-off delay 0..999 s, emptying programs, action set.
// - Start delay 4..99 s default 4 before energising pump 1.
// - Stop delay 0..99 s default 1 before de-energising pump 1.
// - Clean mode: minimum during stop delay stops pump at once.
// - Enabled voltage alarm stops all pumps and flags; disabled gives none.
// - Overvoltage above upper threshold, defaults 440 V or 253 V by variant.
// - Undervoltage below lower threshold, defaults 360 V or 207 V by variant.
// - Voltage alarm only after condition persists for delay 0..99 s default 5.
// - Nominal mains frequency 50..60 Hz, default 50 Hz.
// - Max-start bit, default clear, lets maximum level start the pump.
`timescale 1ns/10ps
module plvs_supervisor
  import plvs_pkg::*;
#(
  parameter int     NPUMP    = 3,
  parameter logic   PHASE3   = 1'b1,
  parameter longint TICK_LEN = TICK_CYC
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_defaults,
  // Settings
  input  wire logic               i_cfg_we,
  input  wire plvs_cfg_type       i_cfg,
  input  wire plvs_mode_type      i_mode,
  input  wire logic [1:0]         i_max_pumps,
  // Sensor, contacts, mains
  input  wire logic               i_sample_vld,
  input  wire logic [LVL_W-1:0]   i_sample,
  input  wire logic               i_float,
  input  wire logic               i_start_contact,
  input  wire logic               i_stop_contact,
  input  wire logic [VOLT_W-1:0]  i_mains_volt,
  // Outputs
  output plvs_cfg_type            o_cfg,
  output logic [LVL_W-1:0]        o_level,
  output plvs_alm_type            o_alarm,
  output logic [NPUMP-1:0]        o_pump_on
);
  plvs_cfg_type           cfg_r;
  plvs_cfg_type           cfg_nxt;
  plvs_cfg_type           cfg_in;
  plvs_cfg_type           cfg_def;
  logic [LVL_W+7:0]       filt_r;
  logic [LVL_W+7:0]       filt_nxt;
  logic [LVL_W-1:0]       lvl_r;
  logic [LVL_W-1:0]       lvl_nxt;
  logic [LVL_W-1:0]       raw_rel;
  plvs_alm_type           alm_r;
  plvs_alm_type           alm_nxt;
  plvs_pump_type          st_r;
  plvs_pump_type          st_nxt;
  logic [NPUMP-1:0]       pump_r;
  logic [NPUMP-1:0]       pump_nxt;
  logic [31:0]            tick_cnt_r;
  logic [31:0]            tick_cnt_nxt;
  logic                   tick;
  logic                   digit_mode;
  logic                   emptying;
  logic                   clean_mode;
  logic                   float_act;
  logic                   float_hold_r;
  logic                   float_hold_nxt;
  logic                   start_cond;
  logic                   stop_cond;
  logic                   min_c;
  logic                   max_c;
  logic                   volt_c;
  logic                   start_done;
  logic                   stop_done;
  logic                   volt_done;
  logic                   float_done;
  logic [LVL_W+7:0]       diff;

  // ****************************************************************
  // Defaults and clamped settings
  // ****************************************************************
  always_comb begin
    cfg_def = '0;
    cfg_def.zero      = ZERO_DEF;
    cfg_def.min_lvl   = MIN_DEF;
    cfg_def.start_lvl = START_DEF;
    cfg_def.stop_lvl  = STOP_DEF;
    cfg_def.max_lvl   = MAXL_DEF;
    cfg_def.coef      = COEF_DEF;
    cfg_def.float_dly = FLT_DLY_DEF;
    cfg_def.start_dly = START_DLY_DEF;
    cfg_def.stop_dly  = STOP_DLY_DEF;
    cfg_def.volt_dly  = VOLT_DLY_DEF;
    cfg_def.vmax      = PHASE3 ? VMAX3_DEF : VMAX1_DEF;
    cfg_def.vmin      = PHASE3 ? VMIN3_DEF : VMIN1_DEF;
    cfg_def.freq      = FREQ_DEF;
    cfg_in = i_cfg;
    if (cfg_in.zero > LVL_MAX_SET) cfg_in.zero = LVL_MAX_SET;
    if (cfg_in.min_lvl > LVL_MAX_SET) cfg_in.min_lvl = LVL_MAX_SET;
    if (cfg_in.start_lvl > LVL_MAX_SET) cfg_in.start_lvl = LVL_MAX_SET;
    if (cfg_in.stop_lvl > LVL_MAX_SET) cfg_in.stop_lvl = LVL_MAX_SET;
    if (cfg_in.max_lvl > LVL_MAX_SET) cfg_in.max_lvl = LVL_MAX_SET;
    if (cfg_in.coef > COEF_MAX) cfg_in.coef = COEF_MAX;
    if (cfg_in.float_dly > FLT_DLY_MAX) cfg_in.float_dly = FLT_DLY_MAX;
    if (cfg_in.start_dly < START_DLY_MIN) cfg_in.start_dly = START_DLY_MIN;
    if (cfg_in.start_dly > START_DLY_MAX) cfg_in.start_dly = START_DLY_MAX;
    if (cfg_in.stop_dly > STOP_DLY_MAX) cfg_in.stop_dly = STOP_DLY_MAX;
    if (cfg_in.volt_dly > VOLT_DLY_MAX) cfg_in.volt_dly = VOLT_DLY_MAX;
    if (PHASE3) begin
      if (cfg_in.vmax < VMAX3_LO) cfg_in.vmax = VMAX3_LO;
      if (cfg_in.vmax > VMAX3_HI) cfg_in.vmax = VMAX3_HI;
      if (cfg_in.vmin < VMIN3_LO) cfg_in.vmin = VMIN3_LO;
      if (cfg_in.vmin > VMIN3_HI) cfg_in.vmin = VMIN3_HI;
    end else begin
      if (cfg_in.vmax < VMAX1_LO) cfg_in.vmax = VMAX1_LO;
      if (cfg_in.vmax > VMAX1_HI) cfg_in.vmax = VMAX1_HI;
      if (cfg_in.vmin < VMIN1_LO) cfg_in.vmin = VMIN1_LO;
      if (cfg_in.vmin > VMIN1_HI) cfg_in.vmin = VMIN1_HI;
    end
    if (cfg_in.freq < FREQ_LO) cfg_in.freq = FREQ_LO;
    if (cfg_in.freq > FREQ_HI) cfg_in.freq = FREQ_HI;
    cfg_nxt = cfg_r;
    if (i_defaults) begin
      cfg_nxt = cfg_def;
    end else if (i_cfg_we) begin
      cfg_nxt = cfg_in;
    end
  end

  // ****************************************************************
  // One-second tick
  // ****************************************************************
  always_comb begin
    tick         = (tick_cnt_r == 32'(TICK_LEN - 1));
    tick_cnt_nxt = tick_cnt_r + 32'h1;
    if (tick || i_defaults) tick_cnt_nxt = '0;
  end

  // ****************************************************************
  // Relative zero and filter
  // ****************************************************************
  always_comb begin
    raw_rel = (i_sample > cfg_r.zero) ? i_sample - cfg_r.zero : '0;
    filt_nxt = filt_r;
    lvl_nxt  = lvl_r;
    diff     = '0;
    if (i_defaults) begin
      filt_nxt = '0;
      lvl_nxt  = '0;
    end else if (i_sample_vld) begin
      // Step of 1/(coef+1) toward the new sample; larger coef is slower
      if ({raw_rel, 8'h00} >= filt_r) begin
        diff     = ({raw_rel, 8'h00} - filt_r) / (22'(cfg_r.coef) + 22'h1);
        filt_nxt = filt_r + diff;
      end else begin
        diff     = (filt_r - {raw_rel, 8'h00}) / (22'(cfg_r.coef) + 22'h1);
        filt_nxt = filt_r - diff;
      end
      lvl_nxt = filt_nxt[LVL_W+7:8];
    end
  end

  // ****************************************************************
  // Conditions
  // ****************************************************************
  always_comb begin
    digit_mode = (i_mode == PLVS_MODE_DIGIT_EMPTY) || (i_mode == PLVS_MODE_DIGIT_FILL)
                 || (i_mode == PLVS_MODE_MULTI_TANK);
    emptying   = (i_mode == PLVS_MODE_DARK_EMPTY) || (i_mode == PLVS_MODE_CLEAN_EMPTY)
                 || (i_mode == PLVS_MODE_DIGIT_EMPTY) || (i_mode == PLVS_MODE_MULTI_TANK);
    clean_mode = (i_mode == PLVS_MODE_CLEAN_EMPTY) || (i_mode == PLVS_MODE_CLEAN_FILL);
    min_c      = (lvl_r <= cfg_r.min_lvl);
    max_c      = (lvl_r >= cfg_r.max_lvl);
    volt_c     = cfg_r.volt_en
                 && ((i_mains_volt > cfg_r.vmax) || (i_mains_volt < cfg_r.vmin));
    float_act  = cfg_r.float_alarm_pump_action;
    start_cond = digit_mode ? (lvl_r >= cfg_r.start_lvl) : i_start_contact;
    stop_cond  = digit_mode ? (lvl_r >= cfg_r.stop_lvl) : i_stop_contact;
    if (cfg_r.max_start_en && max_c) begin
      start_cond = 1'b1;
      stop_cond  = 1'b0;
    end
    float_hold_nxt = i_defaults ? 1'b0 : (i_float && float_act && emptying);
    if (!i_defaults && !i_float && float_hold_r && !float_done) float_hold_nxt = 1'b1;
    alm_nxt             = alm_r;
    alm_nxt.min_alarm   = min_c;
    alm_nxt.max_alarm   = max_c;
    alm_nxt.float_alarm = i_float;
    alm_nxt.volt_alarm  = volt_done;
    if (i_defaults) alm_nxt = '0;
  end

  // ****************************************************************
  // Delay timers
  // ****************************************************************
  plvs_sec_timer #(.W(SEC_W)) u_start_tmr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (st_r == PLVS_P_START_WT && !i_defaults),
    .i_tick  (tick),
    .i_limit (cfg_r.start_dly),
    .o_done  (start_done)
  );

  plvs_sec_timer #(.W(SEC_W)) u_stop_tmr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (st_r == PLVS_P_STOP_WT && !i_defaults),
    .i_tick  (tick),
    .i_limit (cfg_r.stop_dly),
    .o_done  (stop_done)
  );

  plvs_sec_timer #(.W(SEC_W)) u_volt_tmr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (volt_c && !i_defaults),
    .i_tick  (tick),
    .i_limit (cfg_r.volt_dly),
    .o_done  (volt_done)
  );

  plvs_sec_timer #(.W(SEC_W)) u_float_tmr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (float_hold_r && !i_float && !i_defaults),
    .i_tick  (tick),
    .i_limit (cfg_r.float_dly),
    .o_done  (float_done)
  );

  // ****************************************************************
  // Pump 1 sequence and pump outputs
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PLVS_P_OFF: begin
        if (start_cond && !stop_cond && !min_c) st_nxt = PLVS_P_START_WT;
      end
      PLVS_P_START_WT: begin
        if (!start_cond || stop_cond || min_c) st_nxt = PLVS_P_OFF;
        else if (start_done) st_nxt = PLVS_P_RUN;
      end
      PLVS_P_RUN: begin
        if (min_c) st_nxt = PLVS_P_OFF;
        else if (stop_cond) st_nxt = PLVS_P_STOP_WT;
      end
      PLVS_P_STOP_WT: begin
        if (min_c && clean_mode) st_nxt = PLVS_P_OFF;
        else if (start_cond && !stop_cond) st_nxt = PLVS_P_RUN;
        else if (stop_done) st_nxt = PLVS_P_OFF;
      end
      default: st_nxt = PLVS_P_OFF;
    endcase
    if (volt_done || i_defaults) st_nxt = PLVS_P_OFF;
    pump_nxt    = '0;
    pump_nxt[0] = (st_nxt == PLVS_P_RUN) || (st_nxt == PLVS_P_STOP_WT);
    if (float_act && (i_float || float_hold_nxt)) begin
      if (emptying) begin
        for (int i = 0; i < NPUMP; i++) begin
          if (i <= int'(i_max_pumps)) pump_nxt[i] = 1'b1;
        end
      end else begin
        pump_nxt = '0;
      end
    end
    if (volt_done || i_defaults) pump_nxt = '0;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_r        <= '0;
      tick_cnt_r   <= '0;
      filt_r       <= '0;
      lvl_r        <= '0;
      alm_r        <= '0;
      st_r         <= PLVS_P_OFF;
      pump_r       <= '0;
      float_hold_r <= 1'b0;
    end else begin
      cfg_r        <= cfg_nxt;
      tick_cnt_r   <= tick_cnt_nxt;
      filt_r       <= filt_nxt;
      lvl_r        <= lvl_nxt;
      alm_r        <= alm_nxt;
      st_r         <= st_nxt;
      pump_r       <= pump_nxt;
      float_hold_r <= float_hold_nxt;
    end
  end

  assign o_cfg     = cfg_r;
  assign o_level   = lvl_r;
  assign o_alarm   = alm_r;
  assign o_pump_on = pump_r;
endmodule

// >>> verif/plvs_plant_model.sv
`timescale 1ns/10ps
module plvs_plant_model
  import plvs_pkg::*;
(
  // Clock
  input  wire logic             i_clk,
  // Process value
  input  wire logic [LVL_W-1:0] i_level,
  // Sensor side
  output logic                  o_sample_vld,
  output logic [LVL_W-1:0]      o_sample
);
  // *****
  // Sensor converter
  // *****
  logic [1:0] div_r;
  initial begin
    div_r = '0;
    o_sample_vld = 1'b0;
    o_sample = '0;
  end
  // One conversion every fourth cycle; data is junk outside valid
  always @(negedge i_clk) begin
    div_r <= div_r + 2'h1;
    o_sample_vld <= (div_r == 2'h3);
    o_sample <= (div_r == 2'h3) ? i_level : ~i_level;
  end
endmodule

// >>> verif/plvs_supervisor_monitor.sv
`timescale 1ns/10ps
module plvs_supervisor_monitor
  import plvs_pkg::*;
#(
  parameter int   NPUMP  = 3,
  parameter logic PHASE3 = 1'b1
) (
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_reset,
  input wire logic             i_defaults,
  // Settings
  input wire logic             i_cfg_we,
  input wire plvs_cfg_type     i_cfg,
  // Outputs
  input wire plvs_cfg_type     o_cfg,
  input wire logic [LVL_W-1:0] o_level,
  input wire plvs_alm_type     o_alarm,
  input wire logic [NPUMP-1:0] o_pump_on
);
  // *****
  // Checks
  // *****
  localparam logic [VOLT_W-1:0] VMAX_D = PHASE3 ? VMAX3_DEF : VMAX1_DEF;
  localparam logic [VOLT_W-1:0] VMIN_D = PHASE3 ? VMIN3_DEF : VMIN1_DEF;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_ZERO_LOAD: assert property (i_cfg_we && !i_defaults && i_cfg.zero <= LVL_MAX_SET
    |=> o_cfg.zero == $past(i_cfg.zero)) else $error("Zero not loaded");
  AST_ZERO_CLAMP: assert property (i_cfg_we && !i_defaults && i_cfg.zero > LVL_MAX_SET
    |=> o_cfg.zero == LVL_MAX_SET) else $error("Zero not clamped");
  AST_LVL_DEF: assert property (i_defaults |=> o_cfg.zero == ZERO_DEF
    && o_cfg.min_lvl == MIN_DEF && o_cfg.start_lvl == START_DEF
    && o_cfg.stop_lvl == STOP_DEF && o_cfg.max_lvl == MAXL_DEF) else $error("Level defaults");
  AST_DLY_DEF: assert property (i_defaults |=> o_cfg.coef == COEF_DEF
    && o_cfg.float_dly == FLT_DLY_DEF && o_cfg.start_dly == START_DLY_DEF
    && o_cfg.stop_dly == STOP_DLY_DEF) else $error("Delay defaults");
  AST_MISC_DEF: assert property (i_defaults |=> o_cfg.vmax == VMAX_D
    && o_cfg.vmin == VMIN_D && o_cfg.volt_dly == VOLT_DLY_DEF && o_cfg.freq == FREQ_DEF
    && !o_cfg.max_start_en && !o_cfg.float_alarm_pump_action) else $error("Misc defaults");
  AST_DEF_CLEAR: assert property (i_defaults |=> o_alarm == '0 && o_pump_on == '0)
    else $error("Defaults did not clear");
  AST_MAX_ALARM: assert property (!i_defaults ##1 !i_defaults |->
    o_alarm.max_alarm == ($past(o_level) >= $past(o_cfg.max_lvl))) else $error("Max alarm");
  AST_MIN_ALARM: assert property (!i_defaults ##1 !i_defaults |->
    o_alarm.min_alarm == ($past(o_level) <= $past(o_cfg.min_lvl))) else $error("Min alarm");
  AST_VOLT_OFF: assert property ($past(!o_cfg.volt_en) |-> !o_alarm.volt_alarm)
    else $error("Voltage alarm while disabled");
  AST_VOLT_STOP: assert property (o_alarm.volt_alarm [*2] |-> o_pump_on == '0)
    else $error("Pumps run under voltage alarm");
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("Error at %0t: got %h exp %h", $time, (a), (b)); \
  end \
end
module testbench;
  import plvs_pkg::*;
  localparam int TICK = 10;
  logic             clk, reset, dflt, we, vld, flt, start_c, stop_c;
  logic [1:0]       maxp;
  logic [LVL_W-1:0] raw, smp, o_level;
  logic [VOLT_W-1:0] volt;
  logic [2:0]       pump;
  plvs_cfg_type     cfg, o_cfg, c;
  plvs_mode_type    mode;
  plvs_alm_type     alm;
  int               errors, checked;
  plvs_supervisor #(.NPUMP(3), .PHASE3(1'b1), .TICK_LEN(TICK)) plvs_supervisor_i (
    .i_clk(clk), .i_reset(reset), .i_defaults(dflt), .i_cfg_we(we), .i_cfg(cfg),
    .i_mode(mode), .i_max_pumps(maxp), .i_sample_vld(vld), .i_sample(smp),
    .i_float(flt), .i_start_contact(start_c), .i_stop_contact(stop_c),
    .i_mains_volt(volt), .o_cfg(o_cfg), .o_level(o_level), .o_alarm(alm), .o_pump_on(pump));
  plvs_plant_model plvs_plant_model_i (
    .i_clk(clk), .i_level(raw), .o_sample_vld(vld), .o_sample(smp));
  // *****
  // Helpers
  // *****
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic plvs_cfg_type defcfg();
    return '{zero: ZERO_DEF, min_lvl: MIN_DEF, start_lvl: START_DEF, stop_lvl: STOP_DEF,
      max_lvl: MAXL_DEF, coef: COEF_DEF, max_start_en: 1'b0, float_alarm_pump_action: 1'b0,
      float_dly: FLT_DLY_DEF, start_dly: START_DLY_DEF, stop_dly: STOP_DLY_DEF, volt_en: 1'b0,
      vmax: VMAX3_DEF, vmin: VMIN3_DEF, volt_dly: VOLT_DLY_DEF, freq: FREQ_DEF};
  endfunction
  task automatic setup(input plvs_mode_type m, input plvs_cfg_type n);
    @(negedge clk);
    cfg = n;
    we = 1'b1;
    mode = m;
    @(negedge clk);
    we = 1'b0;
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_defaults();
    plvs_cfg_type r;
    dflt = 1'b1;
    w(1);
    dflt = 1'b0;
    r = o_cfg;
    r.volt_en = 1'b0;
    `CHK(r, defcfg());
    `CHK(o_cfg, defcfg());
    raw = 14'h03e8;
    w(20);
    `CHK((o_level > 0) && (o_level < 14'h03e8), 1'b1);
    raw = 14'h0000;
  endtask
  task automatic t_clamp();
    c = defcfg();
    c.zero = 14'h3fff;
    c.coef = 8'hff;
    c.start_dly = 10'h000;
    c.vmax = 10'h3ff;
    setup(PLVS_MODE_DARK_EMPTY, c);
    `CHK(o_cfg.zero, LVL_MAX_SET);
    `CHK(o_cfg.coef, COEF_MAX);
    `CHK(o_cfg.start_dly, START_DLY_MIN);
    `CHK(o_cfg.vmax, VMAX3_HI);
  endtask
  task automatic t_digit();
    c = defcfg();
    c.coef = 8'h00;
    c.zero = 14'h0014;
    c.stop_dly = 10'h003;
    setup(PLVS_MODE_DIGIT_EMPTY, c);
    raw = 14'h00aa;
    w(25);
    `CHK(o_level, 14'h0096);
    `CHK(pump[0], 1'b0);
    w(40);
    `CHK(pump[0], 1'b1);
    raw = 14'h00dc;
    w(10);
    `CHK(pump[0], 1'b1);
    w(35);
    `CHK(pump[0], 1'b0);
  endtask
  task automatic t_clean_min();
    c.stop_dly = 10'h009;
    setup(PLVS_MODE_CLEAN_EMPTY, c);
    raw = 14'h00aa;
    start_c = 1'b1;
    w(65);
    `CHK(pump[0], 1'b1);
    start_c = 1'b0;
    stop_c = 1'b1;
    w(5);
    raw = 14'h001e;
    w(15);
    `CHK(alm.min_alarm, 1'b1);
    `CHK(pump[0], 1'b0);
    stop_c = 1'b0;
  endtask
  task automatic t_max();
    setup(PLVS_MODE_DARK_EMPTY, c);
    raw = 14'h00aa;
    w(60);
    `CHK(pump[0], 1'b0);
    raw = 14'h03fc;
    w(60);
    `CHK(alm.max_alarm, 1'b1);
    `CHK(pump[0], 1'b0);
    c.max_start_en = 1'b1;
    setup(PLVS_MODE_DARK_EMPTY, c);
    w(60);
    `CHK(pump[0], 1'b1);
    raw = 14'h001e;
    c.max_start_en = 1'b0;
    setup(PLVS_MODE_DARK_EMPTY, c);
    w(30);
  endtask
  task automatic t_float();
    setup(PLVS_MODE_CLEAN_EMPTY, c);
    w(30);
    flt = 1'b1;
    w(10);
    `CHK(alm.float_alarm, 1'b1);
    `CHK(pump, 3'b000);
    flt = 1'b0;
    c.float_alarm_pump_action = 1'b1;
    c.float_dly = 10'h002;
    maxp = 2'h1;
    setup(PLVS_MODE_CLEAN_EMPTY, c);
    flt = 1'b1;
    w(60);
    `CHK(pump, 3'b011);
    flt = 1'b0;
    w(8);
    `CHK(pump, 3'b011);
    w(30);
    `CHK(pump, 3'b000);
    setup(PLVS_MODE_CLEAN_FILL, c);
    flt = 1'b1;
    w(60);
    `CHK(pump, 3'b000);
    flt = 1'b0;
  endtask
  task automatic t_volt();
    c.volt_en = 1'b1;
    c.volt_dly = 10'h004;
    raw = 14'h00aa;
    setup(PLVS_MODE_DIGIT_EMPTY, c);
    w(60);
    `CHK(pump[0], 1'b1);
    volt = 10'h1cc;
    w(25);
    `CHK(alm.volt_alarm, 1'b0);
    volt = 10'h190;
    w(5);
    volt = 10'h1cc;
    w(60);
    `CHK(alm.volt_alarm, 1'b1);
    `CHK(pump, 3'b000);
    volt = 10'h190;
    w(5);
    `CHK(alm.volt_alarm, 1'b0);
    volt = 10'h12c;
    w(60);
    `CHK(alm.volt_alarm, 1'b1);
    c.volt_en = 1'b0;
    setup(PLVS_MODE_DIGIT_EMPTY, c);
    w(60);
    `CHK(alm.volt_alarm, 1'b0);
    volt = 10'h190;
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // *****
  // Run
  // *****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
  initial begin
    {reset, dflt, we, flt, start_c, stop_c, maxp, raw} = '0;
    reset = 1'b1;
    cfg = defcfg();
    mode = PLVS_MODE_DARK_EMPTY;
    volt = 10'h190;
    errors = 0;
    checked = 0;
    w(2);
    reset = 1'b0;
    w(1);
    t_defaults();
    t_clamp();
    t_digit();
    t_clean_min();
    t_max();
    t_float();
    t_volt();
    report_and_stop();
  end
endmodule
bind plvs_supervisor plvs_supervisor_monitor #(.NPUMP(NPUMP), .PHASE3(PHASE3)) mon_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_defaults(i_defaults), .i_cfg_we(i_cfg_we),
  .i_cfg(i_cfg), .o_cfg(o_cfg), .o_level(o_level), .o_alarm(o_alarm), .o_pump_on(o_pump_on));
